// ---- rtl/pwc_channel.sv ----
module pwc_channel #(
    parameter int CNT_W = 32
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        capture_input_pin,
    output logic             capture_done_irq
);
    // ====================================================================
    // Parameter check
    if (CNT_W != 32) begin : g_bad_width
        $error("CNT_W must be 32.");
    end

    pwc_pkg::pwc_state_t state_reg;
    pwc_pkg::pwc_state_t state_next;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic        wr;
    logic        rd;
    logic        rise;
    logic        fall;
    logic        valid_edge;
    logic        tick;
    logic [1:0]  edge_sel;
    logic [1:0]  clk_sel;
    logic        mapped;
    logic [1:0]  cap_ev;

    assign wr = psel && penable && pwrite && state_reg.rsp.pready;
    assign rd = psel && !penable && !pwrite;
    assign edge_sel = state_reg.ctrl[pwc_pkg::CTRL_EDGE_LSB +: 2];
    assign clk_sel  = state_reg.ctrl[pwc_pkg::CTRL_CLK_LSB +: 2];
    assign rise = state_reg.pin_q && !state_reg.pin_e;
    assign fall = !state_reg.pin_q && state_reg.pin_e;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= pwc_pkg::OFF_LEVEL);

    // ====================================================================
    // Edge and clock selection
    always_comb begin
        case (edge_sel)
            pwc_pkg::EDGE_FALL: valid_edge = fall;
            pwc_pkg::EDGE_RISE: valid_edge = rise;
            pwc_pkg::EDGE_BOTH: valid_edge = rise || fall;
            default:            valid_edge = 1'b0;
        endcase
        case (clk_sel)
            pwc_pkg::CLK_PERIPHERAL_CLOCK_B: tick = 1'b1;
            pwc_pkg::CLK_DIV2:  tick = (state_reg.prescale[0] == 1'b1);
            pwc_pkg::CLK_DIV4:  tick = (state_reg.prescale[1:0] == 2'h3);
            pwc_pkg::CLK_DIV16: tick = (state_reg.prescale == 4'hF);
            default:            tick = 1'b1;
        endcase
    end

    // ====================================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        cap_ev = 2'h0;
        state_next.pin_d = capture_input_pin;
        state_next.pin_q = state_reg.pin_d;
        state_next.pin_e = state_reg.pin_q;
        state_next.prescale = state_reg.prescale + 4'h1;
        state_next.rsp.pready = psel && !penable;
        state_next.rsp.pslverr = psel && !penable && !mapped;
        state_next.rsp.prdata = 32'h00000000;

        if (state_reg.mode == pwc_pkg::PWC_RUN) begin
            if (valid_edge && state_reg.ctrl[pwc_pkg::CTRL_TRIG_BIT]) begin
                state_next.hold = state_reg.count;
                state_next.count = pwc_pkg::COUNT_CLEAR;
                cap_ev[pwc_pkg::ST_DONE_BIT] = 1'b1;
                if (state_reg.count == '1) begin
                    cap_ev[pwc_pkg::ST_OVF_BIT] = 1'b1;
                end
            end else if (tick && state_reg.count != '1) begin
                state_next.count = state_reg.count + 32'h1;
            end
        end

        if (wr && mapped) begin
            case (paddr)
                pwc_pkg::OFF_CTRL: begin
                    if (pstrb[0]) begin
                        state_next.ctrl = pwdata[6:0];
                    end
                end
                pwc_pkg::OFF_RUN: begin
                    if (pstrb[0] && pwdata[0]) begin
                        state_next.mode = pwc_pkg::PWC_RUN;
                        state_next.count = pwc_pkg::COUNT_CLEAR;
                        state_next.prescale = 4'h0;
                    end
                end
                pwc_pkg::OFF_HALT: begin
                    if (pstrb[0] && pwdata[0]) begin
                        state_next.mode = pwc_pkg::PWC_IDLE;
                    end
                end
                pwc_pkg::OFF_STATUS: begin
                    if (pstrb[0]) begin
                        state_next.status = state_reg.status & ~pwdata[1:0];
                    end
                end
                pwc_pkg::OFF_MASK: begin
                    if (pstrb[0]) begin
                        state_next.mask = pwdata[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        state_next.status = state_next.status | cap_ev;

        if (rd && mapped) begin
            case (paddr)
                pwc_pkg::OFF_CTRL:   state_next.rsp.prdata = {25'h0, state_reg.ctrl};
                pwc_pkg::OFF_RUN:    state_next.rsp.prdata = {31'h0, state_reg.mode == pwc_pkg::PWC_RUN};
                pwc_pkg::OFF_STATUS: state_next.rsp.prdata = {30'h0, state_reg.status};
                pwc_pkg::OFF_MASK:   state_next.rsp.prdata = {30'h0, state_reg.mask};
                pwc_pkg::OFF_HOLD:   state_next.rsp.prdata = state_reg.hold;
                pwc_pkg::OFF_COUNT:  state_next.rsp.prdata = state_reg.count;
                pwc_pkg::OFF_LEVEL:  state_next.rsp.prdata = {31'h0, state_reg.pin_q};
                default:             state_next.rsp.prdata = 32'h00000000;
            endcase
        end
        state_next.irq = |(state_next.status & state_next.mask);
    end

    // ====================================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '{mode: pwc_pkg::PWC_IDLE, ctrl: pwc_pkg::CTRL_RESET,
                           status: 2'h0, mask: 2'h0, count: pwc_pkg::COUNT_CLEAR,
                           hold: 32'h00000000, prescale: 4'h0, pin_d: 1'b0,
                           pin_q: 1'b0, pin_e: 1'b0, irq: 1'b0,
                           rsp: '{prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0}};
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata           = state_reg.rsp.prdata;
    assign pready           = state_reg.rsp.pready;
    assign pslverr          = state_reg.rsp.pslverr;
    assign capture_done_irq = state_reg.irq;
endmodule : pwc_channel

// ---- rtl/pwc_pkg.sv ----
// Behaviour
// - Valid edge selectable, including both edges.
// - Capture trigger bit enables capture on the input valid edge.
// - Counting clock selectable, includes peripheral clock B.
// - Run bit enables, clears, starts the counter.
// - Valid edge copies counter to hold, clears.
// - Capture sets sticky done flag; software clears.
// - Halt bit disables counting.
package pwc_pkg;
    // ====================================================================
    // Register offsets
    localparam logic [7:0]  OFF_CTRL    = 8'h00;
    localparam logic [7:0]  OFF_RUN     = 8'h04;
    localparam logic [7:0]  OFF_HALT    = 8'h08;
    localparam logic [7:0]  OFF_STATUS  = 8'h0C;
    localparam logic [7:0]  OFF_MASK    = 8'h10;
    localparam logic [7:0]  OFF_HOLD    = 8'h14;
    localparam logic [7:0]  OFF_COUNT   = 8'h18;
    localparam logic [7:0]  OFF_LEVEL   = 8'h1C;
    // ====================================================================
    // Field positions
    localparam int          CTRL_EDGE_LSB = 0;
    localparam int          CTRL_TRIG_BIT = 2;
    localparam int          CTRL_CLK_LSB  = 4;
    localparam int          ST_DONE_BIT   = 0;
    localparam int          ST_OVF_BIT    = 1;
    // ====================================================================
    // Reset values and encodings
    localparam logic [1:0]  EDGE_FALL     = 2'h0;
    localparam logic [1:0]  EDGE_RISE     = 2'h1;
    localparam logic [1:0]  EDGE_BOTH     = 2'h2;
    localparam logic [1:0]  CLK_PERIPHERAL_CLOCK_B     = 2'h0;
    localparam logic [1:0]  CLK_DIV2      = 2'h1;
    localparam logic [1:0]  CLK_DIV4      = 2'h2;
    localparam logic [1:0]  CLK_DIV16     = 2'h3;
    localparam logic [6:0]  CTRL_RESET    = 7'h06;
    localparam logic [31:0] COUNT_CLEAR   = 32'h00000000;

    typedef enum logic [0:0] {
        PWC_IDLE = 1'b0,
        PWC_RUN  = 1'b1
    } pwc_mode_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } pwc_apb_rsp_t;

    typedef struct packed {
        pwc_mode_t    mode;
        logic [6:0]   ctrl;
        logic [1:0]   status;
        logic [1:0]   mask;
        logic [31:0]  count;
        logic [31:0]  hold;
        logic [3:0]   prescale;
        logic         pin_d;
        logic         pin_q;
        logic         pin_e;
        logic         irq;
        pwc_apb_rsp_t rsp;
    } pwc_state_t;
endpackage : pwc_pkg

// ---- test/pwc_channel_assertions.sv ----
module pwc_channel_chk #(
    parameter int CNT_W = 32
) (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        capture_input_pin,
    input logic        capture_done_irq
);
    // ====================================================================
    // Checks at the ports.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    acc_ready_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
    ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("answer without setup");
    ready_once_a: assert property (pready |=> !pready) else $error("answer stands too long");
    map_err_a: assert property (psel && !penable && paddr > 8'h1C |=> pslverr) else $error("unmapped not refused");
    map_ok_a: assert property (psel && !penable && paddr <= 8'h1C && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("mapped access refused");
    idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
    irq_cause_a: assert property ($rose(capture_done_irq) |->
        $past(capture_input_pin, 3) != $past(capture_input_pin, 4) || $past(psel && pwrite, 2))
        else $error("interrupt without edge");
    irq_clear_a: assert property ($fell(capture_done_irq) |-> $past(psel && pwrite, 2))
        else $error("interrupt dropped by itself");
endmodule : pwc_channel_chk

bind pwc_channel pwc_channel_chk #(.CNT_W(CNT_W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_pin(capture_input_pin), .capture_done_irq(capture_done_irq));

// ---- test/pwc_pulse_src.sv ----
module pwc_pulse_src (
    input  logic       pclk,
    input  logic       presetn,
    input  logic       en,
    input  logic [7:0] hw,
    input  logic [7:0] lw,
    output logic       pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====================================================================
    // Square wave with high and low widths in whole clock periods.
    logic [7:0] n;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin <= 1'b0;
            n   <= 8'h00;
        end else if (en) begin
            if (n + 8'h01 >= (pin ? hw : lw)) begin
                pin <= ~pin;
                n   <= 8'h00;
            end else begin
                n <= n + 8'h01;
            end
        end
    end
endmodule : pwc_pulse_src

// ---- test/pulse_width_capture_channel_tb.sv ----
module pulse_width_capture_channel_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ====================================================================
    // Bench signals, model state and tasks.
    logic pclk, presetn, psel, penable, pwrite, pin, irq, pready, pslverr, en, e;
    logic [7:0] paddr, hw, lw;
    logic [31:0] pwdata, prdata, r, h, lv, lv2, x;
    int n_errors, cmp_count, k, n_disc;
    integer seed;
    logic [31:0] highs[$], lows[$];
    pwc_channel dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input_pin(pin), .capture_done_irq(irq));
    pwc_pulse_src src (.pclk(pclk), .presetn(presetn), .en(en), .hw(hw), .lw(lw), .pin(pin));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task summarize;
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            summarize();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task wirq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 300) begin
            n_errors++;
            summarize();
        end
    endtask : wirq
    // ====================================================================
    // Main sequence.
    initial begin
        seed = 32'hC1E8;
        {presetn, psel, penable, pwrite, en, paddr, pwdata} = '0;
        hw = 8'(20 + ($random(seed) & 31));
        lw = 8'(20 + ($random(seed) & 31));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0, r); chk(r, 32'h06);
        apb(1'b1, 8'h10, 32'h1, r);
        apb(1'b1, 8'h04, 32'h1, r);
        apb(1'b0, 8'h04, 32'h0, r); chk(r & 32'h1, 32'h1);
        en <= 1'b1;
        k = 0;
        while ((highs.size() < 4 || lows.size() < 4) && k < 12) begin
            wirq();
            apb(1'b0, 8'h14, 32'h0, h);
            apb(1'b0, 8'h1C, 32'h0, lv);
            apb(1'b0, 8'h1C, 32'h0, lv2);
            apb(1'b1, 8'h0C, 32'h1, r); chk({31'h0, irq}, 32'h0);
            if (lv[0] !== lv2[0]) begin
                n_disc++;
            end else if (k > 0) begin
                x = lv[0] ? {24'h0, lw} - 32'h1 : {24'h0, hw} - 32'h1;
                chk(h, x);
                if (lv[0]) lows.push_back(h);
                else highs.push_back(h);
            end
            k++;
        end
        chk(highs.size() + lows.size(), 32'h8);
        chk(n_disc, 32'h0);
        apb(1'b1, 8'h00, 32'h5, r);
        apb(1'b1, 8'h04, 32'h1, r);
        apb(1'b1, 8'h0C, 32'h1, r);
        wirq();
        apb(1'b1, 8'h0C, 32'h1, r);
        wirq();
        apb(1'b0, 8'h14, 32'h0, h);
        chk(h, {24'h0, hw} + {24'h0, lw} - 32'h1);
        apb(1'b1, 8'h08, 32'h1, r);
        apb(1'b0, 8'h04, 32'h0, r); chk(r & 32'h1, 32'h0);
        apb(1'b1, 8'h0C, 32'h1, r);
        repeat (120) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, 8'h20, 32'h0, r); chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        summarize();
    end
endmodule : pulse_width_capture_channel_tb
